// [inc/aes_pkg.sv]
// shared constants and types for the accelerometer event status block
package aes_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [7:0] OFS_MOTION = 8'h09;
	localparam logic [7:0] OFS_DATA_BUF = 8'h0a;
	localparam logic [7:0] OFS_TAP_SLOPE = 8'h0b;
	localparam logic [7:0] OFS_POSE_HIGHG = 8'h0c;
	localparam logic [7:0] OFS_RSVD = 8'h0d;
	localparam logic [7:0] OFS_FILL = 8'h0e;
	localparam logic [7:0] OFS_BUF_CFG = 8'h30;
	localparam logic [7:0] OFS_LATCH_CTRL = 8'h31;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h41;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h42;

	// event flag index, bits 0..7 are the motion byte, 8..10 the data/buffer byte
	localparam int FLG_LOW = 0;
	localparam int FLG_HIGH = 1;
	localparam int FLG_SLOPE = 2;
	localparam int FLG_SLO_NO_MOT = 3;
	localparam int FLG_D_TAP = 4;
	localparam int FLG_S_TAP = 5;
	localparam int FLG_ORIENT = 6;
	localparam int FLG_FLAT = 7;
	localparam int FLG_DRDY = 8;
	localparam int FLG_LEVEL = 9;
	localparam int FLG_FULL = 10;
	localparam int NUM_FLAGS = 11;

	// field positions
	localparam int DRDY_POS = 7;
	localparam int LEVEL_POS = 6;
	localparam int FULL_POS = 5;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_FLAT_EN_POS = 2;
	localparam int CTRL_LATCH_CLR_POS = 7;
	localparam int FILL_OVERRUN_POS = 7;

	// interrupt status bits
	localparam int IRQ_MOTION = 0;
	localparam int IRQ_DRDY = 1;
	localparam int IRQ_LEVEL = 2;
	localparam int IRQ_FULL = 3;
	localparam int IRQ_OVERRUN = 4;
	localparam int IRQ_POSE = 5;
	localparam int IRQ_FLAT = 6;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] IRQ_EN_RST = 8'h00;
	localparam logic [7:0] BUF_CFG_RST = 8'h00;

	// latch modes
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_TEMP = 2'h1;
	localparam logic [1:0] MODE_PERM = 2'h2;

	// timing
	localparam int CLK_MHZ = 100;
	localparam int TEMP_LATCH_MS = 250;
	localparam int TEMP_LATCH_CYC = TEMP_LATCH_MS * 1000 * CLK_MHZ;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [2:0] {
		LS_IDLE = 3'b001,
		LS_HELD = 3'b010,
		LS_TIMED = 3'b100
	} aes_lstate_t;
endpackage

// [rtl/aes_event_latch.sv]
// holds one event flag according to the selected latch mode
`timescale 1ns/100ps
module aes_event_latch #(
	parameter int HOLD_CYC = aes_pkg::TEMP_LATCH_CYC
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic trig,
	input wire logic [1:0] mode,
	input wire logic clear,
	output logic flag
);
	import aes_pkg::*;
	localparam int TW = $clog2(HOLD_CYC + 1);
	localparam logic [TW-1:0] HOLD_LOAD = TW'(HOLD_CYC - 1);
	aes_lstate_t state;
	logic [TW-1:0] timer;

	// a live trigger always shows, whatever the mode
	assign flag = trig | (state != LS_IDLE);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= LS_IDLE;
			timer <= '0;
		end else begin
			case (state)
			LS_IDLE: begin
				if (trig && mode == MODE_TEMP) begin
					state <= LS_TIMED;
					timer <= HOLD_LOAD;
				end else if (trig && mode != MODE_NONE) begin
					state <= LS_HELD;
				end
			end
			LS_HELD: begin
				// set beats clear; reads never clear
				if (clear && !trig) begin
					state <= LS_IDLE;
				end
			end
			LS_TIMED: begin
				if (trig) begin
					timer <= HOLD_LOAD;
				end else if (clear || timer == '0) begin
					state <= LS_IDLE;
				end else begin
					timer <= timer - 1'b1;
				end
			end
			default: state <= LS_IDLE;
			endcase
		end
	end

	latch_set_a: assert property (@(posedge mclk) disable iff (reset)
		trig && mode != MODE_NONE |=> flag)
		else $error("latched flag not set after trigger");
	perm_hold_a: assert property (@(posedge mclk) disable iff (reset)
		state == LS_HELD && !clear |=> flag && state == LS_HELD)
		else $error("held flag dropped without clear");
endmodule

// [rtl/aes_frame_count.sv]
// buffer fill level and overrun flag
`timescale 1ns/100ps
module aes_frame_count #(
	parameter int DEPTH = aes_pkg::FIFO_DEPTH,
	parameter int CW = 7
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic push,
	input wire logic pop,
	input wire logic cfg_wr,
	output logic [CW-1:0] count,
	output logic overrun
);
	import aes_pkg::*;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	logic push_ok;
	logic pop_ok;
	logic lost;

	// a push into a full buffer is only taken when a pop frees a slot
	assign pop_ok = pop && count != '0;
	assign push_ok = push && (count < DEPTH_C || pop_ok);
	assign lost = push && !push_ok;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			count <= '0;
		end else if (cfg_wr) begin
			count <= '0;
		end else if (push_ok && !pop_ok) begin
			count <= count + 1'b1;
		end else if (pop_ok && !push_ok) begin
			count <= count - 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			overrun <= 1'b0;
		end else begin
			overrun <= lost | (overrun & ~cfg_wr);
		end
	end

	overrun_hold_a: assert property (@(posedge mclk) disable iff (reset)
		overrun && !cfg_wr |=> overrun)
		else $error("overrun cleared without config write");
	cfg_clear_a: assert property (@(posedge mclk) disable iff (reset)
		cfg_wr |=> count == '0)
		else $error("frame count not cleared by config write");
	count_bound_a: assert property (@(posedge mclk) disable iff (reset)
		count <= DEPTH_C)
		else $error("frame count above depth");
endmodule

// [rtl/aes_status_regs.sv]
// event status, source, pose and buffer fill registers with interrupt output
`timescale 1ns/100ps

module aes_status_regs #(
	parameter int HOLD_CYC = aes_pkg::TEMP_LATCH_CYC,
	parameter int DEPTH = aes_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [aes_pkg::ADDR_W-1:0] addr,
	input wire logic [aes_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [aes_pkg::DATA_W-1:0] rd_data,
	output logic irq,
	input wire logic [aes_pkg::NUM_FLAGS-1:0] evt_trig,
	input wire logic tap_sign,
	input wire logic [2:0] tap_axis,
	input wire logic slope_sign,
	input wire logic [2:0] slope_axis,
	input wire logic high_sign,
	input wire logic [2:0] high_axis,
	input wire logic flat_in,
	input wire logic [2:0] orient_in,
	input wire logic orient_block,
	input wire logic frame_push,
	input wire logic frame_pop
);
	import aes_pkg::*;

	logic [7:0] ctrl;
	logic [7:0] irq_status;
	logic [7:0] irq_enable;
	logic [7:0] buf_cfg;
	logic [NUM_FLAGS-1:0] flags;
	logic [NUM_FLAGS-1:0] flags_prev;
	logic [3:0] tap_src;
	logic [3:0] slope_src;
	logic [3:0] high_src;
	logic [2:0] orient;
	logic flat_now;
	logic [6:0] fill_count;
	logic overrun;
	logic overrun_prev;
	logic latch_clr;
	logic buf_cfg_wr;
	logic [1:0] latch_mode;
	logic flat_en;
	logic [7:0] irq_events;
	logic [7:0] next_rd_data;

	assign latch_mode = ctrl[CTRL_MODE_LSB +: 2];
	assign flat_en = ctrl[CTRL_FLAT_EN_POS];
	assign latch_clr = wr_strobe && addr == OFS_LATCH_CTRL && wr_data[CTRL_LATCH_CLR_POS];
	assign buf_cfg_wr = wr_strobe && addr == OFS_BUF_CFG;

	// one latch per event flag
	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLAGS; gi = gi + 1) begin : g_flag
			aes_event_latch #(
				.HOLD_CYC(HOLD_CYC)
			) u_latch (
				.mclk(mclk),
				.reset(reset),
				.trig(evt_trig[gi]),
				.mode(latch_mode),
				.clear(latch_clr),
				.flag(flags[gi])
			);
		end
	endgenerate

	aes_frame_count #(
		.DEPTH(DEPTH),
		.CW(7)
	) u_fill (
		.mclk(mclk),
		.reset(reset),
		.push(frame_push),
		.pop(frame_pop),
		.cfg_wr(buf_cfg_wr),
		.count(fill_count),
		.overrun(overrun)
	);

	// control register: latch clear bit is a pulse and is not stored
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrl <= CTRL_RST;
		end else if (wr_strobe && addr == OFS_LATCH_CTRL) begin
			ctrl <= {1'b0, 4'h0, wr_data[2:0]};
		end
	end

	// the buffer config value is kept only so software can read it back
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			buf_cfg <= BUF_CFG_RST;
		end else if (buf_cfg_wr) begin
			buf_cfg <= wr_data;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			irq_enable <= IRQ_EN_RST;
		end else if (wr_strobe && addr == OFS_IRQ_ENABLE) begin
			irq_enable <= wr_data;
		end
	end

	// source bits follow the engine while it reports a trigger
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tap_src <= 4'h0;
		end else if (evt_trig[FLG_S_TAP] || evt_trig[FLG_D_TAP]) begin
			tap_src <= {tap_sign, tap_axis};
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			slope_src <= 4'h0;
		end else if (evt_trig[FLG_SLOPE]) begin
			slope_src <= {slope_sign, slope_axis};
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			high_src <= 4'h0;
		end else if (evt_trig[FLG_HIGH]) begin
			high_src <= {high_sign, high_axis};
		end
	end

	// pose is not latched: it tracks the detector unless blocked
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			orient <= 3'h0;
		end else if (!orient_block) begin
			orient <= orient_in;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			flat_now <= 1'b0;
		end else begin
			flat_now <= flat_in;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			flags_prev <= '0;
			overrun_prev <= 1'b0;
		end else begin
			flags_prev <= flags;
			overrun_prev <= overrun;
		end
	end

	// interrupt events are edges, so a held flag raises only one event
	always_comb begin
		irq_events = 8'h00;
		irq_events[IRQ_MOTION] = |(flags[7:0] & ~flags_prev[7:0]);
		irq_events[IRQ_DRDY] = flags[FLG_DRDY] & ~flags_prev[FLG_DRDY];
		irq_events[IRQ_LEVEL] = flags[FLG_LEVEL] & ~flags_prev[FLG_LEVEL];
		irq_events[IRQ_FULL] = flags[FLG_FULL] & ~flags_prev[FLG_FULL];
		irq_events[IRQ_OVERRUN] = overrun & ~overrun_prev;
		irq_events[IRQ_POSE] = !orient_block && orient_in != orient;
		irq_events[IRQ_FLAT] = flat_in != flat_now;
	end

	// a new event beats a clear in the same cycle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			irq_status <= 8'h00;
		end else if (wr_strobe && addr == OFS_IRQ_CLEAR) begin
			irq_status <= (irq_status & ~wr_data) | irq_events;
		end else begin
			irq_status <= irq_status | irq_events;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// read mux; unmapped and reserved addresses read zero
	always_comb begin
		next_rd_data = 8'h00;
		case (addr)
		OFS_MOTION: next_rd_data = flags[7:0];
		OFS_DATA_BUF: begin
			next_rd_data[DRDY_POS] = flags[FLG_DRDY];
			next_rd_data[LEVEL_POS] = flags[FLG_LEVEL];
			next_rd_data[FULL_POS] = flags[FLG_FULL];
		end
		OFS_TAP_SLOPE: next_rd_data = {tap_src, slope_src};
		OFS_POSE_HIGHG: begin
			// flat means nothing with detection off, so it reads zero
			next_rd_data = {flat_now & flat_en, orient, high_src};
		end
		OFS_RSVD: next_rd_data = 8'h00;
		OFS_FILL: next_rd_data = {overrun, fill_count};
		OFS_BUF_CFG: next_rd_data = buf_cfg;
		OFS_LATCH_CTRL: next_rd_data = ctrl;
		OFS_IRQ_STATUS: next_rd_data = irq_status;
		OFS_IRQ_ENABLE: next_rd_data = irq_enable;
		default: next_rd_data = 8'h00;
		endcase
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_data <= 8'h00;
		end else if (rd_strobe) begin
			rd_data <= next_rd_data;
		end else begin
			rd_data <= 8'h00;
		end
	end

	motion_read_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_MOTION |=> rd_data == $past(flags[7:0]))
		else $error("motion byte does not match flags");
	data_rsvd_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_DATA_BUF
		|=> rd_data[4:0] == 5'h00 && rd_data[DRDY_POS] == $past(flags[FLG_DRDY]))
		else $error("data byte layout wrong");
	tap_source_a: assert property (@(posedge mclk) disable iff (reset)
		evt_trig[FLG_S_TAP] || evt_trig[FLG_D_TAP] |=> tap_src == $past({tap_sign, tap_axis}))
		else $error("tap source not captured");
	slope_source_a: assert property (@(posedge mclk) disable iff (reset)
		evt_trig[FLG_SLOPE] |=> slope_src == $past({slope_sign, slope_axis}))
		else $error("slope source not captured");
	high_source_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_POSE_HIGHG |=> rd_data[3:0] == $past(high_src))
		else $error("high-g source misplaced");
	flat_gate_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_POSE_HIGHG && !flat_en |=> rd_data[7] == 1'b0)
		else $error("flat bit shown while detection off");
	pose_track_a: assert property (@(posedge mclk) disable iff (reset)
		!orient_block |=> orient == $past(orient_in))
		else $error("pose bits not tracking");
	pose_freeze_a: assert property (@(posedge mclk) disable iff (reset)
		orient_block [*2] |-> $stable(orient))
		else $error("pose bits changed while blocked");
	rsvd_read_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_RSVD |=> rd_data == 8'h00)
		else $error("reserved address reads nonzero");
	fill_read_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_FILL |=> rd_data == $past({overrun, fill_count}))
		else $error("fill byte wrong");
	read_keep_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_MOTION && latch_mode == MODE_PERM && flags[FLG_SLO_NO_MOT]
		&& !latch_clr |=> flags[FLG_SLO_NO_MOT])
		else $error("read cleared a latched flag");
	irq_out_a: assert property (@(posedge mclk) disable iff (reset)
		##1 irq == $past(|(irq_status & irq_enable)))
		else $error("interrupt output wrong");
	idle_read_a: assert property (@(posedge mclk) disable iff (reset)
		!rd_strobe |=> rd_data == 8'h00)
		else $error("read data outside read cycle");

	// source bytes: capture only while the engine reports, hold otherwise; read layout of the data and pose bytes
	tap_read_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_TAP_SLOPE |=> rd_data == $past({tap_src, slope_src}))
		else $error("tap and slope byte wrong");
	tap_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!evt_trig[FLG_S_TAP] && !evt_trig[FLG_D_TAP] |=> $stable(tap_src))
		else $error("tap source changed without trigger");
	slope_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!evt_trig[FLG_SLOPE] |=> $stable(slope_src))
		else $error("slope source changed without trigger");
	high_capture_a: assert property (@(posedge mclk) disable iff (reset)
		evt_trig[FLG_HIGH] |=> high_src == $past({high_sign, high_axis}))
		else $error("high-g source not captured");
	high_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!evt_trig[FLG_HIGH] |=> $stable(high_src))
		else $error("high-g source changed without trigger");
	data_bits_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_DATA_BUF |=> rd_data[LEVEL_POS] == $past(flags[FLG_LEVEL])
		&& rd_data[FULL_POS] == $past(flags[FLG_FULL]))
		else $error("level or full bit misplaced");
	pose_bits_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_POSE_HIGHG |=> rd_data[6:4] == $past(orient))
		else $error("pose bits misplaced");
	flat_read_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_POSE_HIGHG && flat_en |=> rd_data[7] == $past(flat_now))
		else $error("flat bit wrong while enabled");

	// control side: clear bit is a pulse, never stored
	ctrl_write_a: assert property (@(posedge mclk) disable iff (reset)
		wr_strobe && addr == OFS_LATCH_CTRL |=> latch_mode == $past(wr_data[1:0])
		&& ctrl[7:3] == 5'h00)
		else $error("latch control not taken");
	ctrl_read_a: assert property (@(posedge mclk) disable iff (reset)
		rd_strobe && addr == OFS_LATCH_CTRL |=> rd_data[CTRL_LATCH_CLR_POS] == 1'b0)
		else $error("latch clear bit reads back");
	enable_write_a: assert property (@(posedge mclk) disable iff (reset)
		wr_strobe && addr == OFS_IRQ_ENABLE |=> irq_enable == $past(wr_data))
		else $error("interrupt enable not taken");
	events_set_a: assert property (@(posedge mclk) disable iff (reset)
		|irq_events |=> (irq_status & $past(irq_events)) == $past(irq_events))
		else $error("interrupt event lost");
	irq_clear_a: assert property (@(posedge mclk) disable iff (reset)
		wr_strobe && addr == OFS_IRQ_CLEAR |=> (irq_status & $past(wr_data & ~irq_events)) == 8'h00)
		else $error("interrupt status not cleared");
	pose_event_a: assert property (@(posedge mclk) disable iff (reset)
		!orient_block && orient_in != orient |=> irq_status[IRQ_POSE])
		else $error("pose change not reported");
	flat_event_a: assert property (@(posedge mclk) disable iff (reset)
		flat_in != flat_now |=> irq_status[IRQ_FLAT])
		else $error("flat change not reported");
	overrun_event_a: assert property (@(posedge mclk) disable iff (reset)
		overrun && !overrun_prev |=> irq_status[IRQ_OVERRUN])
		else $error("overrun not reported");
endmodule

// [tb/aes_host_model.sv]
// host side bus master: one-cycle register writes and reads
`timescale 1ns/100ps
module aes_host_model (
	input wire logic mclk,
	input wire logic [7:0] rd_data,
	output logic [7:0] addr,
	output logic [7:0] wr_data,
	output logic wr_strobe,
	output logic rd_strobe
);
	initial begin
		addr = 8'h00;
		wr_data = 8'h00;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
	end

	// callers may pass ones in reserved bit positions, as the 8'hff writes to the motion and interrupt clear registers do
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_strobe <= 1'b1;
		@(posedge mclk);
		wr_strobe <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge mclk);
		rd_strobe <= 1'b0;
		#1;
		d = rd_data;
	endtask
endmodule

// [tb/aes_status_regs_tb.sv]
// register-level bench for the event status block
`timescale 1ns/100ps
module aes_status_regs_tb;
	import aes_pkg::*;
	localparam int HOLD = 20;
	localparam int DEP = 4;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] addr, wr_data, rd_data, v;
	logic wr_strobe, rd_strobe, irq;
	logic [NUM_FLAGS-1:0] evt_trig = '0;
	logic tap_sign = 1'b0, slope_sign = 1'b0, high_sign = 1'b0, flat_in = 1'b0;
	logic [2:0] tap_axis = '0, slope_axis = '0, high_axis = '0, orient_in = '0;
	logic orient_block = 1'b0, frame_push = 1'b0, frame_pop = 1'b0;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;

	always #5 mclk = ~mclk;

	aes_host_model host (.mclk(mclk), .rd_data(rd_data), .addr(addr), .wr_data(wr_data),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe));

	aes_status_regs #(.HOLD_CYC(HOLD), .DEPTH(DEP)) dut (.mclk(mclk), .reset(reset),
		.addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
		.rd_data(rd_data), .irq(irq), .evt_trig(evt_trig), .tap_sign(tap_sign),
		.tap_axis(tap_axis), .slope_sign(slope_sign), .slope_axis(slope_axis),
		.high_sign(high_sign), .high_axis(high_axis), .flat_in(flat_in),
		.orient_in(orient_in), .orient_block(orient_block), .frame_push(frame_push),
		.frame_pop(frame_pop));

	task automatic complete_run();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, v);
		chk($sformatf("reg %h", a), v, exp);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic pulse(input logic push, input int n);
		repeat (n) begin
			@(posedge mclk);
			frame_push <= push;
			frame_pop <= ~push;
			@(posedge mclk);
			frame_push <= 1'b0;
			frame_pop <= 1'b0;
		end
	endtask

	// hang guard, well above the expected run length
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			complete_run();
		end
	end

	initial begin
		wait_cyc(10);
		reset <= 1'b0;
		for (int i = 0; i < 8; i++) rchk(8'h09 + 8'(i % 6), 8'h00);
		rchk(8'h7f, 8'h00);
		host.wr(OFS_MOTION, 8'hff);
		rchk(OFS_MOTION, 8'h00);
		for (int i = 0; i < NUM_FLAGS; i++) begin
			@(posedge mclk);
			evt_trig <= NUM_FLAGS'(1) << i;
			if (i < 8) rchk(OFS_MOTION, 8'h01 << i);
			else rchk(OFS_DATA_BUF, 8'h80 >> (i - 8));
		end
		@(posedge mclk);
		evt_trig <= '0;
		host.wr(OFS_LATCH_CTRL, 8'h04);
		@(posedge mclk);
		{tap_sign, tap_axis, slope_sign, slope_axis} <= 8'hd2;
		{high_sign, high_axis, flat_in, orient_in} <= {4'hb, 1'b1, 3'b110};
		evt_trig <= 11'h026;
		wait_cyc(3);
		evt_trig <= '0;
		rchk(OFS_TAP_SLOPE, 8'hd2);
		rchk(OFS_POSE_HIGHG, 8'heb);
		@(posedge mclk);
		orient_block <= 1'b1;
		orient_in <= 3'b001;
		wait_cyc(3);
		rchk(OFS_POSE_HIGHG, 8'heb);
		host.wr(OFS_LATCH_CTRL, 8'h06);
		@(posedge mclk);
		orient_block <= 1'b0;
		evt_trig <= 11'h008;
		@(posedge mclk);
		evt_trig <= '0;
		wait_cyc(3);
		rchk(OFS_POSE_HIGHG, 8'h9b);
		rchk(OFS_MOTION, 8'h08);
		rchk(OFS_MOTION, 8'h08);
		host.wr(OFS_LATCH_CTRL, 8'h84);
		rchk(OFS_MOTION, 8'h00);
		rchk(OFS_LATCH_CTRL, 8'h04);
		host.wr(OFS_LATCH_CTRL, 8'h05);
		@(posedge mclk);
		evt_trig <= 11'h001;
		@(posedge mclk);
		evt_trig <= '0;
		wait_cyc(3);
		rchk(OFS_MOTION, 8'h01);
		wait_cyc(HOLD + 5);
		rchk(OFS_MOTION, 8'h00);
		host.wr(OFS_LATCH_CTRL, 8'h04);
		pulse(1'b1, DEP);
		rchk(OFS_FILL, 8'(DEP));
		pulse(1'b1, 1);
		rchk(OFS_FILL, 8'h80 | 8'(DEP));
		pulse(1'b0, DEP + 1);
		rchk(OFS_FILL, 8'h80);
		pulse(1'b1, 2);
		host.wr(OFS_BUF_CFG, 8'h00);
		rchk(OFS_FILL, 8'h00);
		host.wr(OFS_IRQ_CLEAR, 8'hff);
		host.wr(OFS_IRQ_ENABLE, 8'h02);
		rchk(OFS_IRQ_ENABLE, 8'h02);
		@(posedge mclk);
		evt_trig <= 11'h100;
		@(posedge mclk);
		evt_trig <= '0;
		wait_cyc(3);
		chk("irq raised", {7'h00, irq}, 8'h01);
		host.wr(OFS_IRQ_ENABLE, 8'h00);
		wait_cyc(2);
		chk("irq masked", {7'h00, irq}, 8'h00);
		rchk(OFS_IRQ_STATUS, 8'h02);
		host.wr(OFS_IRQ_ENABLE, 8'h02);
		wait_cyc(2);
		chk("irq unmasked", {7'h00, irq}, 8'h01);
		host.wr(OFS_IRQ_CLEAR, 8'h02);
		wait_cyc(2);
		chk("irq cleared", {7'h00, irq}, 8'h00);
		rchk(OFS_IRQ_STATUS, 8'h00);
		complete_run();
	end
endmodule
